// file: include/acrp_pkg.sv
/*
 * Constants and types shared by the codec routing and preset block.
 * Assumes a single 100 MHz clock domain; nothing else.
 */
`default_nettype none
package acrp_pkg;
   // ==========================================================
   // Register map
   // ==========================================================
   localparam logic [3:0] ADR_DEC_SRC = 4'h0;  // Decoder source select
   localparam logic [3:0] ADR_DEC_STAT = 4'h1; // Format, loudness value
   localparam logic [3:0] ADR_MD_SINK = 4'h2;  // Metadata sink port
   localparam logic [3:0] ADR_ENC_SEL = 4'h3;  // Four encoder selectors
   localparam logic [3:0] ADR_MD_SRC = 4'h4;   // Metadata origin
   localparam logic [3:0] ADR_ENC_VAR = 4'h5;  // Encoder variant (RO)
   localparam logic [3:0] ADR_PRESET = 4'h6;   // Preset command
   localparam logic [3:0] ADR_PRE_STAT = 4'h7; // Preset lamps / valid
   localparam logic [3:0] ADR_FIFO = 4'h8;     // Metadata word FIFO read

   // ==========================================================
   // Field positions and widths
   // ==========================================================
   localparam int SEL_W = 4;             // Decoder source code width
   localparam int PAIR_W = 3;            // Mixer pair code width
   localparam int PORT_W = 2;            // Serial port index width
   localparam int NPORT = 4;             // Serial ports
   localparam int NENC = 4;              // Encoder pair inputs
   localparam int NSLOT = 5;             // Preset slots
   localparam int SLOT_W = 3;            // Slot number width
   localparam int DN_W = 5;              // Loudness value width
   localparam int CFG_W = 24;            // Saved configuration width
   localparam int MD_W = 8;              // Metadata word width
   localparam int FIFO_D = 8;            // Metadata FIFO depth
   localparam int PRE_SAVE_BIT = 3;      // Save flag in preset command
   localparam int CHMAX_CONS = 6;        // Consumer format channel cap
   localparam int CHMAX_BCST = 8;        // Broadcast format channel cap

   // Decoder sources: codes 0..7 embedded pairs, 8..15 digital pairs
   localparam logic [SEL_W-1:0] SRC_AES_13 = 4'he;  // Pair 13/14
   localparam logic [SEL_W-1:0] SRC_AES_15 = 4'hf;  // Pair 15/16
   localparam logic [SEL_W-1:0] DEC_SRC_RST = 4'h0;

   // Metadata origin: 0..3 serial ports, 4 decoder
   localparam logic [2:0] MDS_DECODER = 3'h4;

   // ==========================================================
   // Enumerations
   // ==========================================================
   typedef enum logic [2:0] {
      ACRP_FMT_NONE, ACRP_FMT_BCST, ACRP_FMT_CONS,
      ACRP_FMT_PCM, ACRP_FMT_UNK
   } acrp_fmt_t;

   typedef enum logic [1:0] {
      ACRP_ENC_NONE, ACRP_ENC_BCST, ACRP_ENC_CONS
   } acrp_enc_t;
endpackage
`default_nettype wire

// file: rtl/acrp_fifo.sv
/*
 * Small synchronous FIFO with valid/ready on both sides.
 * Assumes one clock and an asynchronous active-high reset.
 */
`timescale 1ns/1ps
`default_nettype none
module acrp_fifo #(
   parameter int W = 8,
   parameter int D = 8
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [W-1:0] in_data,
   input wire logic in_valid,
   output logic in_ready,
   output logic [W-1:0] out_data,
   output logic out_valid,
   input wire logic out_ready
);
   localparam int AW = $clog2(D);
   logic [W-1:0] mem [D];           // Storage words
   logic [AW-1:0] wp_r, rp_r;       // Pointers
   logic [AW:0] cnt_r;              // Fill count
   logic push, pop;

   assign in_ready = (cnt_r != (AW+1)'(D));
   assign out_valid = (cnt_r != '0);
   assign out_data = mem[rp_r];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   // ==========================================================
   // Pointer and count update
   // ==========================================================
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         wp_r <= '0;
         rp_r <= '0;
         cnt_r <= '0;
      end else begin
         if (push) begin
            wp_r <= (wp_r == AW'(D-1)) ? '0 : wp_r + 1'b1;
         end
         if (pop) begin
            rp_r <= (rp_r == AW'(D-1)) ? '0 : rp_r + 1'b1;
         end
         cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
      end
   end

   // Storage write, no reset needed
   always_ff @(posedge clk) begin
      if (push) begin
         mem[wp_r] <= in_data;
      end
   end
endmodule
`default_nettype wire

// file: rtl/acrp_top.sv
/*
 * Codec routing, metadata steering, status and preset store.
 * Assumes a plain register port on the system clock; codec cores,
 * mixer and serial ports sit outside and talk through plain ports.
 */
// Behaviour
// (R01) Decoder takes one of sixteen pairs
// (R02) Reduced variant drops digital pairs 13-16
// (R03) Only one compressed stream decoded
// (R04) Format report: broadcast, consumer, PCM, none, unknown
// (R05) Decoder output capped at six or eight
// (R06) Decoder metadata goes to one serial port
// (R07) Port used only when strapped for data
// (R08) Loudness value comes from decoded stream
// (R09) Four encoder pair inputs, one stream
// (R10) Each selector picks a mixer pair
// (R11) Encoder channel cap six or eight
// (R12) Read-only encoder variant report
// (R13) Encoder metadata from ports or decoder
// (R14) Decoder metadata always offered to encoder
// (R15) Save stores configuration, lights slot
// (R16) Recall of filled slot loads and lights
// (R17) Recall of empty slot changes nothing; here it leaves the configuration but clears all slot lamps
`timescale 1ns/1ps
`default_nettype none
module acrp_top #(
   parameter bit REDUCED = 1'b0    // Reduced connector variant
) (
   input wire logic clk,
   input wire logic sys_rst,

   // Register port
   input wire logic [3:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,

   // Decoder side
   input wire logic dec_fmt_valid,
   input wire logic [2:0] dec_fmt,
   input wire logic [4:0] dec_loud,
   input wire logic dec_loud_valid,
   input wire logic [7:0] dec_md_data,
   input wire logic dec_md_valid,
   output logic dec_md_ready,
   output logic [3:0] dec_src,
   output logic [3:0] dec_chmax,

   // Encoder side
   input wire logic [1:0] enc_variant,
   output logic [11:0] enc_pair_sel,
   output logic [3:0] enc_chmax,
   output logic [2:0] enc_md_src,
   output logic [7:0] enc_md_data,
   output logic enc_md_valid,

   // Serial ports
   input wire logic [3:0] ser_data_strap,
   output logic [3:0] ser_md_en,
   output logic [7:0] ser_md_data,
   output logic ser_md_valid,
   input wire logic ser_md_ready
);
   // ==========================================================
   // State
   // ==========================================================
   typedef struct packed {
      logic [3:0] dec_src;          // Decoder source
      logic [1:0] sink;             // Metadata sink port
      logic [11:0] enc_sel;         // Four mixer pair codes
      logic [2:0] md_src;           // Metadata origin
      logic [2:0] fmt;              // Latched format report
      logic [4:0] loud;             // Latched loudness value
      logic [4:0] lamp;             // Slot indicators
      logic [4:0] full;             // Slot holds data
      logic [31:0] rdata;           // Read data
      logic [3:0] dec_chmax;
      logic [3:0] enc_chmax;
      logic [3:0] ser_en;
      logic [7:0] ser_d;
      logic ser_v;
      logic [7:0] enc_d;
      logic enc_v;
   } acrp_st_t;

   acrp_st_t st_r, st_nxt;
   logic [23:0] slot_mem_r [5];     // Preset store
   logic [23:0] cur_cfg;            // Active configuration word
   logic [7:0] f_data;
   logic f_valid, f_ready, f_in_ready;
   logic pre_save, pre_hit;
   logic [2:0] pre_slot;

   // Channel cap for a coded format
   function automatic logic [3:0] chcap(input logic [2:0] f);
      if (f == 3'(acrp_pkg::ACRP_FMT_BCST)) begin
         chcap = 4'(acrp_pkg::CHMAX_BCST);
      end else if (f == 3'(acrp_pkg::ACRP_FMT_CONS)) begin
         chcap = 4'(acrp_pkg::CHMAX_CONS);
      end else begin
         chcap = 4'h0;
      end
   endfunction

   // Legal decoder source for this variant
   function automatic logic src_ok(input logic [3:0] s);
      src_ok = !(REDUCED && (s == acrp_pkg::SRC_AES_13 ||
                             s == acrp_pkg::SRC_AES_15));
   endfunction

   // Slot word: source, sink, selectors, origin, spare
   assign cur_cfg = {st_r.dec_src, st_r.sink, st_r.enc_sel,
                     st_r.md_src, 3'h0};
   // Preset command: save flag and slot number
   assign pre_save = reg_wdata[acrp_pkg::PRE_SAVE_BIT];
   assign pre_slot = reg_wdata[2:0];
   assign pre_hit = reg_wr && reg_addr == acrp_pkg::ADR_PRESET &&
                    pre_slot < 3'(acrp_pkg::NSLOT);

   // ==========================================================
   // Decoder metadata FIFO, drained to serial port and encoder
   // ==========================================================
   acrp_fifo #(.W(acrp_pkg::MD_W), .D(acrp_pkg::FIFO_D)) u_fifo (
      .clk(clk),
      .sys_rst(sys_rst),
      .in_data(dec_md_data),
      .in_valid(dec_md_valid),
      .in_ready(f_in_ready),
      .out_data(f_data),
      .out_valid(f_valid),
      .out_ready(f_ready)
   );

   // Stall only when a strapped sink port is busy
   assign f_ready = !st_r.ser_v || ser_md_ready || !(|st_r.ser_en);

   // ==========================================================
   // Next state
   // ==========================================================
   always_comb begin
      st_nxt = st_r;
      st_nxt.rdata = 32'h0;

      // Register writes
      if (reg_wr) begin
         unique case (reg_addr)
            acrp_pkg::ADR_DEC_SRC: begin
               // Single source; illegal reduced codes ignored
               if (src_ok(reg_wdata[3:0])) begin // see (R01) (R02) (R03)
                  st_nxt.dec_src = reg_wdata[3:0];
               end
            end
            acrp_pkg::ADR_MD_SINK: begin
               st_nxt.sink = reg_wdata[1:0];   // see (R06)
            end
            acrp_pkg::ADR_ENC_SEL: begin
               st_nxt.enc_sel = reg_wdata[11:0]; // see (R09) (R10)
            end
            acrp_pkg::ADR_MD_SRC: begin
               // Five legal origins, others ignored
               if (reg_wdata[2:0] <= acrp_pkg::MDS_DECODER) begin
                  st_nxt.md_src = reg_wdata[2:0]; // see (R13)
               end
            end
            default: begin
            end
         endcase
      end

      // Preset save or recall
      if (pre_hit) begin
         if (pre_save) begin
            st_nxt.full[pre_slot] = 1'b1;    // see (R15)
            st_nxt.lamp = 5'h0;
            st_nxt.lamp[pre_slot] = 1'b1;
         end else if (st_r.full[pre_slot]) begin
            st_nxt.lamp = 5'h0;               // see (R16)
            st_nxt.lamp[pre_slot] = 1'b1;
            st_nxt.dec_src = slot_mem_r[pre_slot][23:20];
            st_nxt.sink = slot_mem_r[pre_slot][19:18];
            st_nxt.enc_sel = slot_mem_r[pre_slot][17:6];
            st_nxt.md_src = slot_mem_r[pre_slot][5:3];
         end else begin
            st_nxt.lamp = 5'h0;               // see (R17)
         end
      end

      // Status from decoder stream
      if (dec_fmt_valid) begin
         st_nxt.fmt = (dec_fmt > 3'(acrp_pkg::ACRP_FMT_UNK)) ?
                      3'(acrp_pkg::ACRP_FMT_UNK) : dec_fmt; // see (R04)
      end
      if (dec_loud_valid) begin
         st_nxt.loud = dec_loud;              // see (R08)
      end

      // Channel caps follow the latched format and variant
      st_nxt.dec_chmax = chcap(st_r.fmt);     // see (R05)
      st_nxt.enc_chmax = chcap(3'(enc_variant)); // see (R11)

      // Sink enabled only on a data-strapped port
      st_nxt.ser_en = 4'h0;
      st_nxt.ser_en[st_r.sink] = ser_data_strap[st_r.sink]; // see (R07)

      // Serial sink output register
      if (st_r.ser_v && ser_md_ready) begin
         st_nxt.ser_v = 1'b0;
      end
      if (f_valid && f_ready && |st_r.ser_en) begin
         st_nxt.ser_d = f_data;
         st_nxt.ser_v = 1'b1;
      end

      // Encoder always sees decoder words
      st_nxt.enc_v = f_valid && f_ready;      // see (R14)
      st_nxt.enc_d = f_data;

      // Register reads
      if (reg_rd) begin
         unique case (reg_addr)
            acrp_pkg::ADR_DEC_SRC: st_nxt.rdata = 32'(st_r.dec_src);
            acrp_pkg::ADR_DEC_STAT: begin
               st_nxt.rdata = {19'h0, st_r.loud, 5'h0, st_r.fmt};
            end
            acrp_pkg::ADR_MD_SINK: st_nxt.rdata = 32'(st_r.sink);
            acrp_pkg::ADR_ENC_SEL: st_nxt.rdata = 32'(st_r.enc_sel);
            acrp_pkg::ADR_MD_SRC: st_nxt.rdata = 32'(st_r.md_src);
            acrp_pkg::ADR_ENC_VAR: begin
               st_nxt.rdata = 32'(enc_variant); // see (R12)
            end
            acrp_pkg::ADR_PRE_STAT: begin
               st_nxt.rdata = {22'h0, st_r.full, st_r.lamp};
            end
            acrp_pkg::ADR_FIFO: begin
               st_nxt.rdata = {23'h0, f_in_ready, f_data};
            end
            default: st_nxt.rdata = 32'h0;
         endcase
      end
   end

   // ==========================================================
   // State register
   // ==========================================================
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         // Decoder is the metadata origin out of reset
         st_r <= '0;
         st_r.md_src <= acrp_pkg::MDS_DECODER;
      end else begin
         st_r <= st_nxt;
      end
   end

   // Preset store write
   always_ff @(posedge clk) begin
      if (pre_hit && pre_save) begin
         slot_mem_r[pre_slot] <= cur_cfg;    // see (R15)
      end
   end

   // ==========================================================
   // Outputs
   // ==========================================================
   // Register port
   assign reg_rdata = st_r.rdata;

   // Decoder side
   assign dec_md_ready = f_in_ready;
   assign dec_src = st_r.dec_src;
   assign dec_chmax = st_r.dec_chmax;

   // Encoder side
   assign enc_pair_sel = st_r.enc_sel;
   assign enc_chmax = st_r.enc_chmax;
   assign enc_md_src = st_r.md_src;
   assign enc_md_data = st_r.enc_d;
   assign enc_md_valid = st_r.enc_v;

   // Serial ports
   assign ser_md_en = st_r.ser_en;
   assign ser_md_data = st_r.ser_d;
   assign ser_md_valid = st_r.ser_v;

   // ==========================================================
   // Checks
   // ==========================================================
   property p_src_legal;
      @(posedge clk) disable iff (sys_rst)
         REDUCED |-> !(dec_src == acrp_pkg::SRC_AES_13 ||
                       dec_src == acrp_pkg::SRC_AES_15);
   endproperty
   a_src_legal: assert property (p_src_legal) // see (R02)
      else $error("reduced variant routed a dropped pair");

   property p_src_write;
      @(posedge clk) disable iff (sys_rst)
         (reg_wr && reg_addr == acrp_pkg::ADR_DEC_SRC &&
          src_ok(reg_wdata[3:0]) && !pre_hit)
         |=> dec_src == $past(reg_wdata[3:0]);
   endproperty
   a_src_write: assert property (p_src_write) // see (R01)
      else $error("decoder source not taken");

   property p_dec_cap;
      @(posedge clk) disable iff (sys_rst)
         ##1 dec_chmax == chcap($past(st_r.fmt));
   endproperty
   a_dec_cap: assert property (p_dec_cap) // see (R05)
      else $error("decoder channel cap wrong");

   property p_strap;
      @(posedge clk) disable iff (sys_rst)
         |ser_md_en |-> |(ser_md_en & $past(ser_data_strap));
   endproperty
   a_strap: assert property (p_strap) // see (R07)
      else $error("metadata sent to unstrapped port");

   property p_one_port;
      @(posedge clk) disable iff (sys_rst)
         $onehot0(ser_md_en);
   endproperty
   a_one_port: assert property (p_one_port) // see (R06)
      else $error("more than one sink port enabled");

   property p_loud;
      @(posedge clk) disable iff (sys_rst)
         dec_loud_valid |=> st_r.loud == $past(dec_loud);
   endproperty
   a_loud: assert property (p_loud) // see (R08)
      else $error("loudness value not from stream");

   property p_enc_md;
      @(posedge clk) disable iff (sys_rst)
         (f_valid && f_ready) |=> enc_md_valid;
   endproperty
   a_enc_md: assert property (p_enc_md) // see (R14)
      else $error("encoder lost decoder metadata");

   property p_empty;
      @(posedge clk) disable iff (sys_rst)
         (pre_hit && !pre_save && !st_r.full[pre_slot])
         |=> $stable(cur_cfg) && st_r.lamp == 5'h0;
   endproperty
   a_empty: assert property (p_empty) // see (R17)
      else $error("empty slot recall changed state");

   property p_save;
      @(posedge clk) disable iff (sys_rst)
         (pre_hit && pre_save) |=> st_r.full[$past(pre_slot)] &&
                                  st_r.lamp[$past(pre_slot)];
   endproperty
   a_save: assert property (p_save) // see (R15)
      else $error("save did not mark slot");

   property p_fmt_range;
      @(posedge clk) disable iff (sys_rst)
         dec_fmt_valid |=> st_r.fmt <= 3'(acrp_pkg::ACRP_FMT_UNK);
   endproperty
   a_fmt_range: assert property (p_fmt_range) // see (R04)
      else $error("format report out of range");

   property p_recall;
      @(posedge clk) disable iff (sys_rst)
         (pre_hit && !pre_save && st_r.full[pre_slot]) |=>
            cur_cfg == $past(slot_mem_r[pre_slot]) && $onehot(st_r.lamp);
   endproperty
   a_recall: assert property (p_recall) // see (R16)
      else $error("recall did not load the slot");
endmodule
`default_nettype wire

// file: verif/acrp_peer_model.sv
/*
 * Far-side model: decoder core status and metadata, serial port sink.
 * Assumes the bench calls its tasks and runs one clock, clk.
 */
`timescale 1ns/1ps
`default_nettype none
module acrp_peer_model (
   input wire logic clk,
   input wire logic dec_md_ready,
   output logic dec_fmt_valid,
   output logic [2:0] dec_fmt,
   output logic [4:0] dec_loud,
   output logic dec_loud_valid,
   output logic [7:0] dec_md_data,
   output logic dec_md_valid,
   output logic ser_md_ready
);
   // ==========================================================
   // Idle levels
   // ==========================================================
   initial begin
      dec_fmt_valid = 1'b0;
      dec_fmt = 3'h5;
      dec_loud = 5'h1a;
      dec_loud_valid = 1'b0;
      dec_md_data = 8'h5a;
      dec_md_valid = 1'b0;
      ser_md_ready = 1'b1;
   end
   // One-cycle status pulse; lines then show the inverse value
   task send_fmt(input logic [2:0] f, input logic [4:0] l);
      @(posedge clk);
      dec_fmt <= f;
      dec_loud <= l;
      dec_fmt_valid <= 1'b1;
      dec_loud_valid <= 1'b1;
      @(posedge clk);
      dec_fmt_valid <= 1'b0;
      dec_loud_valid <= 1'b0;
      dec_fmt <= ~f;
      dec_loud <= ~l;
   endtask
   // Metadata word held until ready is seen at an edge, or 4 edges
   task push(input logic [7:0] w, output bit ok);
      logic r;
      int n;
      ok = 1'b0;
      n = 0;
      @(posedge clk);
      dec_md_data <= w;
      dec_md_valid <= 1'b1;
      while (!ok && n < 4) begin
         @(negedge clk);
         r = dec_md_ready;
         @(posedge clk);
         ok = (r === 1'b1);
         n++;
      end
      dec_md_valid <= 1'b0;
      dec_md_data <= ~w;
   endtask
   // Serial port stall control
   task set_ready(input logic b);
      @(posedge clk);
      ser_md_ready <= b;
   endtask
endmodule
`default_nettype wire

// file: verif/acrp_tb_top.sv
/*
 * Self-checking bench for the codec routing and preset block.
 * Assumes the peer model drives decoder and serial port inputs.
 */
`timescale 1ns/1ps
`default_nettype none
module acrp_tb_top;
   // ==========================================================
   // Signals
   // ==========================================================
   logic clk, sys_rst, reg_wr, reg_rd, dec_fmt_valid, dec_loud_valid;
   logic dec_md_valid, dec_md_ready, enc_md_valid, ser_md_valid;
   logic ser_md_ready;
   logic [3:0] reg_addr, dec_src, dec_chmax, enc_chmax, ser_md_en;
   logic [3:0] ser_data_strap, red_src;
   logic [31:0] reg_wdata, reg_rdata, d;
   logic [2:0] dec_fmt, enc_md_src;
   logic [4:0] dec_loud;
   logic [7:0] dec_md_data, enc_md_data, ser_md_data;
   logic [1:0] enc_variant;
   logic [11:0] enc_pair_sel;
   logic [7:0] enc_q[$], ser_q[$];
   int fails = 0, checked = 0, cyc = 0;
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // ==========================================================
   // Instances: full variant, reduced variant, peer
   // ==========================================================
   acrp_top #(.REDUCED(1'b0)) i_dut (.clk(clk), .sys_rst(sys_rst),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .dec_fmt_valid(dec_fmt_valid), .dec_fmt(dec_fmt),
      .dec_loud(dec_loud), .dec_loud_valid(dec_loud_valid),
      .dec_md_data(dec_md_data), .dec_md_valid(dec_md_valid),
      .dec_md_ready(dec_md_ready), .dec_src(dec_src),
      .dec_chmax(dec_chmax), .enc_variant(enc_variant),
      .enc_pair_sel(enc_pair_sel), .enc_chmax(enc_chmax),
      .enc_md_src(enc_md_src), .enc_md_data(enc_md_data),
      .enc_md_valid(enc_md_valid), .ser_data_strap(ser_data_strap),
      .ser_md_en(ser_md_en), .ser_md_data(ser_md_data),
      .ser_md_valid(ser_md_valid), .ser_md_ready(ser_md_ready));
   acrp_top #(.REDUCED(1'b1)) i_dut_red (.clk(clk), .sys_rst(sys_rst),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(), .dec_fmt_valid(dec_fmt_valid),
      .dec_fmt(dec_fmt), .dec_loud(dec_loud),
      .dec_loud_valid(dec_loud_valid), .dec_md_data(dec_md_data),
      .dec_md_valid(dec_md_valid), .dec_md_ready(), .dec_src(red_src),
      .dec_chmax(), .enc_variant(enc_variant), .enc_pair_sel(),
      .enc_chmax(), .enc_md_src(), .enc_md_data(), .enc_md_valid(),
      .ser_data_strap(ser_data_strap), .ser_md_en(), .ser_md_data(),
      .ser_md_valid(), .ser_md_ready(ser_md_ready));
   acrp_peer_model i_pm (.clk(clk), .dec_md_ready(dec_md_ready),
      .dec_fmt_valid(dec_fmt_valid), .dec_fmt(dec_fmt),
      .dec_loud(dec_loud), .dec_loud_valid(dec_loud_valid),
      .dec_md_data(dec_md_data), .dec_md_valid(dec_md_valid),
      .ser_md_ready(ser_md_ready));
   // Collect words leaving toward encoder and serial port
   always @(negedge clk) begin
      if (enc_md_valid === 1'b1) enc_q.push_back(enc_md_data);
      if (ser_md_valid === 1'b1 && ser_md_ready) ser_q.push_back(ser_md_data);
   end
   // Hang guard
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         fails++;
         tally_and_finish();
      end
   end
   // ==========================================================
   // Bus and compare tasks
   // ==========================================================
   task wr(input logic [3:0] a, input logic [31:0] v);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   task rd(input logic [3:0] a, output logic [31:0] v);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 v = reg_rdata;
   endtask
   task chk(input string n, input logic [31:0] e, input logic [31:0] g);
      checked++;
      if (g !== e) begin
         fails++;
         $display("ERROR %s expected %h seen %h", n, e, g);
      end
   endtask
   task tally_and_finish();
      $display("checks %0d mismatches %0d", checked, fails);
      if (fails == 0 && checked > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   // ==========================================================
   // Scenarios
   // ==========================================================
   task t_reset();
      #1 chk("src_rst", 32'h4, {29'h0, enc_md_src});
      chk("dsrc_rst", 32'h0, {28'h0, dec_src});
      rd(4'hf, d);
      chk("unmapped", 32'h0, d);
   endtask
   task t_dec_src();
      for (int i = 0; i < 16; i++) begin
         wr(acrp_pkg::ADR_DEC_SRC, i);
         rd(acrp_pkg::ADR_DEC_SRC, d);
         chk("dec_src", i, {28'h0, dec_src});
         chk("dec_src_rb", i, d);
         chk("red_src", (i > 13) ? 13 : i, {28'h0, red_src});
      end
   endtask
   task t_format();
      logic [2:0] f;
      for (int k = 0; k < 6; k++) begin
         f = (k == 5) ? 3'h7 : 3'(k);
         i_pm.send_fmt(f, 5'(3 * k + 1));
         repeat (3) @(posedge clk);
         #1 chk("dec_chmax", (f == 1) ? 8 : (f == 2) ? 6 : 0,
                dec_chmax);
         rd(acrp_pkg::ADR_DEC_STAT, d);
         chk("status", (3 * k + 1) << 8 | (f > 4 ? 4 : f),
             d);
      end
   endtask
   task t_enc();
      wr(acrp_pkg::ADR_ENC_SEL, 32'hfac);
      rd(acrp_pkg::ADR_ENC_SEL, d);
      chk("pair_sel", 32'hfac, {20'h0, enc_pair_sel});
      chk("pair_sel_rb", 32'hfac, d);
      for (int v = 0; v < 3; v++) begin
         @(posedge clk);
         enc_variant <= 2'(v);
         repeat (3) @(posedge clk);
         #1 chk("enc_chmax", (v == 1) ? 8 : (v == 2) ? 6 : 0,
                enc_chmax);
         rd(acrp_pkg::ADR_ENC_VAR, d);
         chk("enc_var", v, d);
      end
   endtask
   task t_md_src();
      for (int s = 5; s >= 0; s--) begin
         wr(acrp_pkg::ADR_MD_SRC, s);
         rd(acrp_pkg::ADR_MD_SRC, d);
         chk("md_src", (s > 4) ? 4 : s, {29'h0, enc_md_src});
         chk("md_src_rb", (s > 4) ? 4 : s, d);
      end
   endtask
   task t_stream();
      bit ok;
      int n;
      @(posedge clk);
      ser_data_strap <= 4'h2;
      wr(acrp_pkg::ADR_MD_SINK, 32'h2);
      repeat (2) @(posedge clk);
      #1 chk("ser_en_nostrap", 32'h0, {28'h0, ser_md_en});
      wr(acrp_pkg::ADR_MD_SINK, 32'h1);
      repeat (2) @(posedge clk);
      #1 chk("ser_en", 32'h2, {28'h0, ser_md_en});
      i_pm.set_ready(1'b0);
      enc_q.delete();
      ser_q.delete();
      n = 0;
      ok = 1'b1;
      while (ok && n < 12) begin
         i_pm.push(8'(8'ha0 + n), ok);
         if (ok) n++;
      end
      chk("fill_refused", 32'h0, {31'h0, ok});
      chk("fill_deep", 32'h1, (n >= acrp_pkg::FIFO_D));
      rd(acrp_pkg::ADR_FIFO, d);
      chk("fifo_full", 32'h0, {31'h0, d[8]});
      i_pm.set_ready(1'b1);
      repeat (40) @(posedge clk);
      chk("enc_count", n, enc_q.size());
      chk("ser_count", n, ser_q.size());
      for (int i = 0; i < n && i < enc_q.size() && i < ser_q.size();
           i++) begin
         chk("enc_word", 8'ha0 + i, {24'h0, enc_q[i]});
         chk("ser_word", 8'ha0 + i, {24'h0, ser_q[i]});
      end
      ser_data_strap <= 4'h0;
      repeat (2) @(posedge clk);
      #1 chk("ser_en_off", 32'h0, {28'h0, ser_md_en});
      enc_q.delete();
      ser_q.delete();
      for (int i = 0; i < 3; i++) i_pm.push(8'(8'h30 + i), ok);
      repeat (20) @(posedge clk);
      chk("enc_nostrap", 32'h3, enc_q.size());
      chk("ser_nostrap", 32'h0, ser_q.size());
   endtask
   task t_preset();
      wr(acrp_pkg::ADR_DEC_SRC, 32'h5);
      wr(acrp_pkg::ADR_ENC_SEL, 32'h123);
      wr(acrp_pkg::ADR_MD_SRC, 32'h2);
      wr(acrp_pkg::ADR_PRESET, 32'ha);
      rd(acrp_pkg::ADR_PRE_STAT, d);
      chk("save_lamp", 32'h084, {22'h0, d[9:0]});
      wr(acrp_pkg::ADR_DEC_SRC, 32'h9);
      wr(acrp_pkg::ADR_ENC_SEL, 32'h777);
      wr(acrp_pkg::ADR_MD_SRC, 32'h1);
      wr(acrp_pkg::ADR_PRESET, 32'h2);
      rd(acrp_pkg::ADR_PRE_STAT, d);
      chk("recall_lamp", 32'h084, {22'h0, d[9:0]});
      chk("recall_src", 32'h5, {28'h0, dec_src});
      chk("recall_enc", 32'h123, {20'h0, enc_pair_sel});
      chk("recall_md", 32'h2, {29'h0, enc_md_src});
      wr(acrp_pkg::ADR_PRESET, 32'h4);
      rd(acrp_pkg::ADR_PRE_STAT, d);
      chk("empty_lamp", 32'h080, {22'h0, d[9:0]});
      chk("empty_src", 32'h5, {28'h0, dec_src});
      wr(acrp_pkg::ADR_PRESET, 32'hc);
      wr(acrp_pkg::ADR_PRESET, 32'h5);
      rd(acrp_pkg::ADR_PRE_STAT, d);
      chk("slot_edge", 32'h290, {22'h0, d[9:0]});
   endtask
   // ==========================================================
   // Main sequence
   // ==========================================================
   initial begin
      sys_rst = 1'b1;
      reg_addr = 4'h0;
      reg_wdata = 32'h0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      enc_variant = 2'h0;
      ser_data_strap = 4'h0;
      repeat (20) @(posedge clk);
      sys_rst <= 1'b0;
      @(posedge clk);
      t_reset();
      t_dec_src();
      t_format();
      t_enc();
      t_md_src();
      t_stream();
      t_preset();
      tally_and_finish();
   end
endmodule
`default_nettype wire
